//--- rtl/clock_output_generator.v
// Programmable clock output generator with APB registers and pin routing
//
// Function
// - Output derived from oscillator, not system divider
// - Integer division factor 1 to 31
// - Optional 1:1 duty for odd factors
// - Finish running period before new factor
// - Disable finishes period, then holds low
// - Enable gates waveform only, not pins
// - Pin-select routes clock to GPIO4, GPIO6
// - Reference enable forces GPIO3 to input
// - Clear bit resets divider, registered pulse
// - Bit 7 reads back divider idle status
// - Clear with new factor applies it immediately
// - Invert at end of chain, idle high
// - Inversion change takes effect immediately
// - Factors 0 and 1 pass oscillator clock
// - Plain mode: odd factor low part shorter
// - Symmetry mode gives exact 1:1 duty
`timescale 1ns/100ps
`include "clkout_defs.vh"

module clock_output_generator (
	input wire pclk,
	input wire presetn,
	input wire [`APB_ADDR_W-1:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`APB_DATA_W-1:0] pwdata,
	output reg [`APB_DATA_W-1:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire gpio3_in,
	input wire gpio3_norm_out,
	input wire gpio3_norm_oe,
	input wire gpio4_norm_out,
	input wire gpio4_norm_oe,
	input wire gpio6_norm_out,
	input wire gpio6_norm_oe,
	output reg gpio3_out,
	output reg gpio3_oe,
	output reg gpio4_out,
	output reg gpio4_oe,
	output reg gpio6_out,
	output reg gpio6_oe,
	output reg ref_clk,
	output reg clk_out
);

	// Byte address of a register from its index
	function [`APB_ADDR_W-1:0] word_addr;
		input [`APB_ADDR_W-1:0] index;
		begin
			word_addr = {index[`APB_ADDR_W-3:0], 2'b00};
		end
	endfunction

	// Factors 0 and 1 both mean undivided
	function [`DIV_W-1:0] eff_div;
		input [`DIV_W-1:0] d;
		begin
			if (d <= `DIV_PASS) begin
				eff_div = `DIV_PASS;
			end else begin
				eff_div = d;
			end
		end
	endfunction

	// Last phase of a period: one oscillator cycle is two phases
	function [`CNT_W-1:0] period_last;
		input [`DIV_W-1:0] d;
		reg [`CNT_W-1:0] e;
		begin
			e = {1'b0, eff_div(d)};
			period_last = {e[`CNT_W-2:0], 1'b0} - `CNT_ONE;
		end
	endfunction

	// Number of low phases at the start of a period
	function [`CNT_W-1:0] low_len;
		input [`DIV_W-1:0] d;
		input s;
		reg [`CNT_W-1:0] e;
		begin
			e = {1'b0, eff_div(d)};
			if (s || !e[0] || e == `CNT_ONE) begin
				low_len = e;
			end else begin
				low_len = e - `CNT_ONE;
			end
		end
	endfunction

	// Read data of a mapped register; unmapped reads give zero
	function [`APB_DATA_W-1:0] read_word;
		input sel_setup;
		input sel_port;
		input idle;
		input [7:0] setup;
		input [7:0] port;
		begin
			if (sel_setup) begin
				read_word = {`PAD_ZERO_24, idle, setup[`INV_BIT:0]};
			end else if (sel_port) begin
				read_word = {`PAD_ZERO_24, port};
			end else begin
				read_word = `RDATA_ZERO;
			end
		end
	endfunction

	// Pin drive pair {oe, out}: clock when selected, else normal port logic
	function [1:0] pin_route;
		input sel;
		input wave;
		input norm_out;
		input norm_oe;
		begin
			if (sel) begin
				pin_route = {1'b1, wave};
			end else begin
				pin_route = {norm_oe, norm_out};
			end
		end
	endfunction

	// Divider states
	localparam ST_IDLE = 1'b0;
	localparam ST_RUN = 1'b1;

	reg [7:0] setup_r;
	reg [7:0] port_r;
	reg clr_r;
	reg state_r;
	reg state_nxt;
	reg [`CNT_W-1:0] cnt_r;
	reg [`CNT_W-1:0] cnt_nxt;
	reg [`DIV_W-1:0] div_act_r;
	reg [`DIV_W-1:0] div_act_nxt;
	reg sym_act_r;
	reg sym_act_nxt;
	reg gen_nxt;
	reg wave_nxt;
	reg [1:0] pin4_nxt;
	reg [1:0] pin6_nxt;
	reg gpio3_oe_nxt;
	reg ref_nxt;

	wire hit_setup;
	wire hit_port;
	wire access;
	wire first_access;
	wire wr_fire;
	wire setup_wr;
	wire port_wr;
	wire clr_req;
	wire clken;
	wire refen;
	wire [`DIV_W-1:0] div_req;
	wire sym_req;
	wire period_end;
	wire idle_status;

	assign hit_setup = (paddr == word_addr(`SETUP_INDEX));
	assign hit_port = (paddr == word_addr(`PORT_INDEX));
	assign access = psel && penable;
	// First access cycle; pready answers one cycle later
	assign first_access = access && !pready;
	// A write lands only at the edge where pready is seen high
	assign wr_fire = access && pready && pwrite;
	assign setup_wr = wr_fire && hit_setup;
	assign port_wr = wr_fire && hit_port;
	assign clr_req = setup_wr && pwdata[`CLR_BIT];
	assign clken = port_r[`CLKEN_BIT];
	assign refen = port_r[`REFEN_BIT];
	assign div_req = setup_r[`DIV_MSB:`DIV_LSB];
	assign sym_req = setup_r[`SYM_BIT];
	assign period_end = (cnt_r == period_last(div_act_r));

	// Idle also while only the undivided clock runs
	assign idle_status = (state_r == ST_IDLE) || (eff_div(div_act_r) == `DIV_PASS);

	// APB slave: one wait state, then answer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= `RDATA_ZERO;
		end else begin
			pready <= first_access;
			if (first_access) begin
				pslverr <= !(hit_setup || hit_port);
				if (pwrite) begin
					prdata <= `RDATA_ZERO;
				end else begin
					prdata <= read_word(hit_setup, hit_port, idle_status, setup_r, port_r);
				end
			end else begin
				pslverr <= 1'b0;
				prdata <= `RDATA_ZERO;
			end
		end
	end

	// Register file
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			setup_r <= `SETUP_RESET;
			port_r <= `PORT_RESET;
		end else begin
			if (setup_wr) begin
				// Clear bit is not stored; it reads back as idle status
				setup_r <= {1'b0, pwdata[`INV_BIT:0]};
			end
			if (port_wr) begin
				// Low bits are stored as written; software keeps them zero
				port_r <= pwdata[7:0];
			end
		end
	end

	// Clear pulse registered so it comes one cycle after the write enable, when the new setup value is stored
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clr_r <= 1'b0;
		end else begin
			clr_r <= clr_req;
		end
	end

	// Divider sequencing
	always @* begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		div_act_nxt = div_act_r;
		sym_act_nxt = sym_act_r;
		// Clear wins over every other divider action
		if (clr_r) begin
			// Clear drops the period and takes the new factor at once
			state_nxt = ST_IDLE;
			cnt_nxt = `CNT_ZERO;
			div_act_nxt = div_req;
			sym_act_nxt = sym_req;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (clken) begin
						// Factor and symmetry taken together, never mixed in a period
						state_nxt = ST_RUN;
						cnt_nxt = `CNT_ZERO;
						div_act_nxt = div_req;
						sym_act_nxt = sym_req;
					end
				end
				ST_RUN: begin
					if (period_end) begin
						cnt_nxt = `CNT_ZERO;
						if (clken) begin
							// New settings only at a period boundary
							div_act_nxt = div_req;
							sym_act_nxt = sym_req;
						end else begin
							state_nxt = ST_IDLE;
						end
					end else begin
						cnt_nxt = cnt_r + `CNT_ONE;
					end
				end
				default: begin
					state_nxt = ST_IDLE;
				end
			endcase
		end
	end

	// Waveform: low first, then high; stopped means low before inversion
	always @* begin
		gen_nxt = (state_nxt == ST_RUN) && (cnt_nxt >= low_len(div_act_nxt, sym_act_nxt));
		// Inverter is last and live, so a late change may cut a pulse short
		wave_nxt = gen_nxt ^ setup_r[`INV_BIT];
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_IDLE;
			cnt_r <= `CNT_ZERO;
			div_act_r <= `DIV_PASS;
			sym_act_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			div_act_r <= div_act_nxt;
			sym_act_r <= sym_act_nxt;
		end
	end

	// Pin function follows the select bits only, not the enable
	always @* begin
		pin4_nxt = pin_route(port_r[`SEL_GPIO4_BIT], wave_nxt, gpio4_norm_out, gpio4_norm_oe);
		pin6_nxt = pin_route(port_r[`SEL_GPIO6_BIT], wave_nxt, gpio6_norm_out, gpio6_norm_oe);
	end

	// Reference input wins over the normal port setup
	always @* begin
		if (refen) begin
			gpio3_oe_nxt = 1'b0;
			// Sampled once here; a user of the reference resynchronises it
			ref_nxt = gpio3_in;
		end else begin
			gpio3_oe_nxt = gpio3_norm_oe;
			ref_nxt = 1'b0;
		end
	end

	// Generated clock and pin routing
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_out <= 1'b0;
			gpio4_out <= 1'b0;
			gpio4_oe <= 1'b0;
			gpio6_out <= 1'b0;
			gpio6_oe <= 1'b0;
		end else begin
			clk_out <= wave_nxt;
			gpio4_out <= pin4_nxt[0];
			gpio4_oe <= pin4_nxt[1];
			gpio6_out <= pin6_nxt[0];
			gpio6_oe <= pin6_nxt[1];
		end
	end

	// Reference clock input overrides the normal port setup
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gpio3_out <= 1'b0;
			gpio3_oe <= 1'b0;
			ref_clk <= 1'b0;
		end else begin
			gpio3_out <= gpio3_norm_out;
			gpio3_oe <= gpio3_oe_nxt;
			ref_clk <= ref_nxt;
		end
	end

endmodule

//--- rtl/clkout_defs.vh
// Register map, field positions and reset values of the clock output generator
`ifndef CLKOUT_DEFS_VH
`define CLKOUT_DEFS_VH

// APB address and data widths in bits
`define APB_ADDR_W 12
`define APB_DATA_W 32

// Register indices; the byte address is four times the index
`define SETUP_INDEX 12'h08f
`define PORT_INDEX 12'h0b6

// Reset values
`define SETUP_RESET 8'h00
`define PORT_RESET 8'h00

// Fields of clock_output_setup
`define CLR_BIT 7
`define INV_BIT 6
`define SYM_BIT 5
`define DIV_MSB 4
`define DIV_LSB 0

// Fields of port_settings
`define SEL_GPIO6_BIT 5
`define SEL_GPIO4_BIT 4
`define CLKEN_BIT 3
`define REFEN_BIT 2

// Divider constants
`define DIV_W 5
`define CNT_W 6
`define DIV_PASS 5'h01
`define CNT_ZERO 6'h00
`define CNT_ONE 6'h01

// Bus answer constants
`define RDATA_ZERO 32'h0000_0000
`define PAD_ZERO_24 24'h00_0000

`endif

//--- test/clkout_checker_assertions.sv
// Port-level checks of the clock output generator
`timescale 1ns/100ps
module clkout_checker (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pready,
	input wire pslverr,
	input wire clk_out,
	input wire [31:0] prdata,
	input wire gpio3_in,
	input wire gpio3_oe,
	input wire ref_clk,
	input wire gpio4_norm_out,
	input wire gpio4_norm_oe,
	input wire gpio4_out,
	input wire gpio4_oe,
	input wire gpio6_norm_out,
	input wire gpio6_norm_oe,
	input wire gpio6_out,
	input wire gpio6_oe
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	ready_wait_a: assert property (psel && penable && !pready |=> pready) else $error("wait");
	ready_pulse_a: assert property (pready |=> !pready) else $error("pulse");
	err_ready_a: assert property (pslverr |-> pready) else $error("err");
	rdata_idle_a: assert property (!pready |-> prdata == 0) else $error("rdata");
	ref_copy_a: assert property (ref_clk |-> $past(gpio3_in)) else $error("ref");
	ref_input_a: assert property (ref_clk |-> !gpio3_oe) else $error("oe3");
	pin4_route_a: assert property (gpio4_out != clk_out |->
		gpio4_out == $past(gpio4_norm_out) && gpio4_oe == $past(gpio4_norm_oe)) else $error("p4");
	pin6_route_a: assert property (gpio6_out != clk_out |->
		gpio6_out == $past(gpio6_norm_out) && gpio6_oe == $past(gpio6_norm_oe)) else $error("p6");
	cover property (pslverr);
	cover property (ref_clk);
	cover property ($fell(gpio6_out) && gpio6_oe);
endmodule

//--- test/clk_receiver.sv
// Far-side chip that measures the received clock and sources a reference
`timescale 1ns/100ps
module clk_receiver (
	input wire pclk,
	input wire presetn,
	input wire clk_in,
	output logic [5:0] lo_len,
	output logic [5:0] hi_len,
	output logic got,
	output logic ref_src
);
	logic prev;
	logic [5:0] lo_c, hi_c;
	logic [2:0] rc;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{prev, lo_c, hi_c, lo_len, hi_len, got, rc, ref_src} <= '0;
		end else begin
			prev <= clk_in;
			got <= prev && !clk_in;
			rc <= rc + 3'd1;
			// Reference runs free, unrelated to the divider
			if (rc == 3'd4) ref_src <= ~ref_src;
			lo_c <= clk_in ? 6'd0 : lo_c + 6'd1;
			hi_c <= clk_in ? hi_c + 6'd1 : 6'd0;
			if (clk_in && !prev) lo_len <= lo_c;
			if (!clk_in && prev) hi_len <= hi_c;
		end
	end
endmodule

//--- test/tb_clock_output_generator.sv
// Self-checking bench of the clock output generator
`timescale 1ns/100ps
`include "clkout_defs.vh"
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
	$display("[FAIL] %s exp %h got %h", n, e, a); end end
module tb_clock_output_generator;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, x = 8;
	logic pready, pslverr, gpio3_oe, gpio3_out, gpio4_out, gpio4_oe, gpio6_out, gpio6_oe;
	logic ref_clk, clk_out, got, ref_src;
	logic [5:0] nrm = 0, lo_len, hi_len;
	logic [11:0] exp_len;
	logic [32:0] rq[$];
	logic [11:0] pq[$];
	logic [4:0] dv[6] = '{5'd0, 5'd1, 5'd2, 5'd3, 5'd6, 5'd31};
	int miscompares = 0, cmp_count = 0;
	localparam logic [11:0] SA = 12'(`SETUP_INDEX * 4), PA = 12'(`PORT_INDEX * 4);
	clock_output_generator dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .gpio3_in(ref_src), .gpio3_norm_out(nrm[0]),
		.gpio3_norm_oe(nrm[1]), .gpio4_norm_out(nrm[2]), .gpio4_norm_oe(nrm[3]),
		.gpio6_norm_out(nrm[4]), .gpio6_norm_oe(nrm[5]), .gpio3_out, .gpio3_oe,
		.gpio4_out, .gpio4_oe, .gpio6_out, .gpio6_oe, .ref_clk, .clk_out);
	clk_receiver rx (.pclk, .presetn, .clk_in(gpio4_out), .lo_len, .hi_len, .got, .ref_src);
	initial forever #25 pclk = ~pclk;
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	always @(posedge pclk) begin
		x <= xs(x);
		nrm <= x[5:0];
	end
	always @(posedge pclk) begin
		if (pready === 1'b1) begin
			`CHK("pslverr", rq[0][32], pslverr)
			if (!pwrite) `CHK("prdata", rq[0][31:0], prdata)
			void'(rq.pop_front());
		end
		if (got === 1'b1 && pq.size() > 0) begin
			exp_len = pq.pop_front();
			`CHK("period", exp_len, {lo_len, hi_len})
		end
	end
	task automatic final_report;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
		input logic [32:0] e);
		rq.push_back(e);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task automatic measure(input logic [11:0] e);
		repeat (2) @(posedge got);
		@(negedge got);
		pq.push_back(e);
		@(posedge got);
		@(negedge got);
	endtask
	task automatic run(input logic [4:0] d, input logic s);
		logic [5:0] n;
		n = (d < 2) ? 6'd1 : {1'b0, d};
		apb(1, SA, {2'b10, s, d}, 33'h0);
		apb(1, PA, 8'hf8, 33'h0);
		measure((s || !n[0] || n == 1) ? {n, n} : {n - 6'd1, n + 6'd1});
		apb(0, SA, 0, {25'h0, n == 1, 1'b0, s, d});
		$display("test div %0d sym %0d done", d, s);
	endtask
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1;
		apb(0, SA, 0, 33'h80);
		apb(0, PA, 0, 33'h0);
		apb(0, 12'h004, 0, {1'b1, 32'h0});
		apb(1, 12'h004, 8'h55, {1'b1, 32'h0});
		apb(1, PA, 8'hc0, 33'h0);
		apb(0, PA, 0, 33'hc0);
		$display("test registers done");
		foreach (dv[i]) for (int s = 0; s < 2; s++) run(dv[i], s[0]);
		apb(1, SA, 8'h22, 33'h0);
		measure({6'd2, 6'd2});
		$display("test boundary switch done");
		apb(1, PA, 8'h30, 33'h0);
		repeat (70) @(posedge pclk);
		`CHK("clk_out low", 1'b0, clk_out)
		`CHK("gpio4 oe", 1'b1, gpio4_oe)
		apb(0, SA, 0, 33'ha2);
		apb(1, SA, 8'h7f, 33'h0);
		@(posedge pclk);
		`CHK("clk_out inv", 1'b1, clk_out)
		`CHK("gpio6 inv", 1'b1, gpio6_out)
		apb(1, PA, 8'h04, 33'h0);
		repeat (20) @(posedge pclk);
		`CHK("gpio3 oe", 1'b0, gpio3_oe)
		$display("test pins done");
		final_report;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		final_report;
	end
endmodule
bind clock_output_generator clkout_checker chk (.pclk, .presetn, .psel, .penable, .pready,
	.pslverr, .clk_out, .prdata, .gpio3_in, .gpio3_oe, .ref_clk, .gpio4_norm_out,
	.gpio4_norm_oe, .gpio4_out, .gpio4_oe, .gpio6_norm_out, .gpio6_norm_oe, .gpio6_out,
	.gpio6_oe);
